// >>> rtl/sdbae_pkg.sv
// ---------------------------------------------------------------
// Constants shared by the burst access controller
// ---------------------------------------------------------------
package sdbae_pkg;

    // ---------------------------------------------------------------
    // Clock and timing
    // ---------------------------------------------------------------
    localparam int CLK_MHZ   = 25;
    localparam int T_RP_NS   = 20;   // Precharge time, plain default
    localparam int T_RAS_NS  = 42;   // Least active time, plain default
    localparam int T_WR_CYC  = 2;    // Write recovery in clocks
    // Least times round up to whole cycles
    localparam int T_RP_CYC  = (T_RP_NS * CLK_MHZ + 999) / 1000;
    localparam int T_RAS_CYC = (T_RAS_NS * CLK_MHZ + 999) / 1000;
    localparam int T_DAL_CYC = T_WR_CYC + T_RP_CYC;

    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_COL  = 8'h04;
    localparam logic [7:0] OFS_CFG  = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam int         DATA_BIT = 5;    // Offsets 0x20..0x3C: data

    // Control fields
    localparam int CTRL_GO      = 0;
    localparam int CTRL_WR      = 1;
    localparam int CTRL_AP      = 2;
    localparam int CTRL_BANK_LO = 3;
    localparam int CTRL_ROW     = 5;
    localparam int CTRL_MASK_LO = 6;

    // Configuration fields and reset value
    localparam int         CFG_BL_LO  = 0;
    localparam int         CFG_CL_LO  = 3;
    localparam int         CFG_FPW_LO = 5;
    localparam logic [7:0] CFG_RST    = 8'hF3;

    // Status fields
    localparam int STAT_BUSY   = 0;
    localparam int STAT_REFUSE = 1;
    localparam int STAT_CNT_LO = 2;
    localparam int STAT_TRAS   = 6;

    // Burst length codes
    localparam logic [2:0] BL_1  = 3'h0;
    localparam logic [2:0] BL_2  = 3'h1;
    localparam logic [2:0] BL_4  = 3'h2;
    localparam logic [2:0] BL_8  = 3'h3;
    localparam logic [2:0] BL_FP = 3'h7;

    // Pin commands as {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP   = 4'h7;
    localparam logic [3:0] CMD_READ  = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_STOP  = 4'h6;

    // Auto-precharge address bit
    localparam int A_AP_BIT = 10;

    // Sequencer states
    typedef enum logic [4:0] {
        S_IDLE   = 5'h01,
        S_ARM    = 5'h02,
        S_WBURST = 5'h04,
        S_RBURST = 5'h08,
        S_RECOV  = 5'h10
    } sdbae_state_type;

endpackage

// >>> rtl/sdbae_timer.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Loadable down counter, done while at zero
// ---------------------------------------------------------------
module sdbae_timer #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] value_i,
    output logic              done_o
);
    logic [W-1:0] count_reg;

    // Load wins over counting so a restart is never lost
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= '0;
        end else if (load_i) begin
            count_reg <= value_i;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    assign done_o = (count_reg == '0);
endmodule

// >>> rtl/sdbae_ctrl.sv
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/1ps
// What this block does
// - Read command: cs_n and cas_n low, ras_n and we_n high; column on addr.
// - Write command: cs_n, cas_n, we_n low, ras_n high; column on addr.
// - First write word with the command, one per edge, extras ignored.
// - Write over pending read data needs byte masks on first two cycles.
// - Data drivers released one cycle before read data appears.
// - Burst stop ends full-page bursts only; illegal for other lengths.
// - Burst stop: ras_n, cas_n high with cs_n, we_n low.
// - No read, write or precharge into an auto-precharge burst.
// - Wait precharge time before reactivating after read precharge.
// - Never request auto-precharge with full-page length.
// - Write auto-precharge: two clocks then precharge; wait both.
// - Activate to internal precharge must meet least active time.
// - Accesses stay in the open row; other rows need reactivation.
module sdbae_ctrl #(
    parameter int COL_W = 10,
    parameter int DEPTH = 8
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Memory pins
    output logic             cke_o,
    output logic             cs_n_o,
    output logic             ras_n_o,
    output logic             cas_n_o,
    output logic             we_n_o,
    output logic [11:0]      addr_o,
    output logic             bank_sel_lo_o,
    output logic             bank_sel_hi_o,
    output logic             upper_byte_mask_o,
    output logic             lower_byte_mask_o,
    output logic [15:0]      dq_o,
    output logic             dq_oe_o,
    input  wire logic [15:0] dq_i
);
    // ---------------------------------------------------------------
    // Registers and state
    // ---------------------------------------------------------------
    sdbae_pkg::sdbae_state_type state_reg;
    logic [15:0]      wr_mem [DEPTH];
    logic [15:0]      rd_mem [DEPTH];
    logic [7:1]       ctrl_reg;
    logic [COL_W-1:0] col_reg;
    logic [7:0]       cfg_reg;
    logic             refuse_reg;
    logic             go_reg;
    logic             row_reg;
    logic             ack_reg;
    logic [31:0]      dat_reg;
    logic [3:0]       cmd_reg;
    logic [11:0]      addr_reg;
    logic [1:0]       bank_reg;
    logic [1:0]       mask_reg;
    logic [15:0]      dq_reg;
    logic             oe_reg;
    logic [4:0]       cnt_reg;
    logic [3:0]       rd_cnt_reg;
    logic             op_ap_reg;
    logic             op_wr_reg;
    logic             rec_load_reg;
    logic [7:0]       rec_val_reg;
    logic             rec_done;
    logic             tras_done;
    logic [2:0]       bl;
    logic [1:0]       cl;
    logic             fp;
    logic [3:0]       nwords;
    logic             ap_eff;
    logic             req;
    logic             wr_ok;
    logic             busy;
    logic [4:0]       ridx;
    logic             dat_hit;

    assign bl     = cfg_reg[sdbae_pkg::CFG_BL_LO +: 3];
    assign cl     = cfg_reg[sdbae_pkg::CFG_CL_LO +: 2];
    assign fp     = (bl == sdbae_pkg::BL_FP);
    assign ap_eff = ctrl_reg[sdbae_pkg::CTRL_AP] & ~fp;
    assign req    = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr_ok  = req & wb_we_i & (&wb_sel_i[1:0]);
    assign busy   = (state_reg != sdbae_pkg::S_IDLE);
    assign ridx   = cnt_reg - 5'(cl) - 5'h01;
    // Data window is one block only; offsets above it stay unmapped
    assign dat_hit = ((wb_adr_i >> sdbae_pkg::DATA_BIT) == 8'h01);

    // Words per burst; full page runs a software count then stops
    always_comb begin
        unique case (bl)
            sdbae_pkg::BL_1:  nwords = 4'h1;
            sdbae_pkg::BL_2:  nwords = 4'h2;
            sdbae_pkg::BL_4:  nwords = 4'h4;
            sdbae_pkg::BL_8:  nwords = 4'h8;
            sdbae_pkg::BL_FP:
                nwords = {1'b0, cfg_reg[sdbae_pkg::CFG_FPW_LO +: 3]} + 4'h1;
            default:          nwords = 4'h1;
        endcase
    end

    // ---------------------------------------------------------------
    // Wishbone slave
    // ---------------------------------------------------------------
    // One wait state; unmapped addresses answer with zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req;
            dat_reg <= 32'h0000_0000;
            if (req && !wb_we_i) begin
                if (dat_hit) begin
                    dat_reg[15:0] <= rd_mem[wb_adr_i[4:2]];
                end else if (wb_adr_i == sdbae_pkg::OFS_CTRL) begin
                    dat_reg[7:1] <= ctrl_reg;
                end else if (wb_adr_i == sdbae_pkg::OFS_COL) begin
                    dat_reg[COL_W-1:0] <= col_reg;
                end else if (wb_adr_i == sdbae_pkg::OFS_CFG) begin
                    dat_reg[7:0] <= cfg_reg;
                end else if (wb_adr_i == sdbae_pkg::OFS_STAT) begin
                    dat_reg[sdbae_pkg::STAT_BUSY]   <= busy;
                    dat_reg[sdbae_pkg::STAT_REFUSE] <= refuse_reg;
                    dat_reg[sdbae_pkg::STAT_CNT_LO +: 4] <= rd_cnt_reg;
                    dat_reg[sdbae_pkg::STAT_TRAS]   <= tras_done;
                end
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    // Setup writes are ignored while a burst runs, so it stays coherent
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= 7'h00;
            col_reg  <= '0;
            cfg_reg  <= sdbae_pkg::CFG_RST;
        end else if (wr_ok && !busy) begin
            if (wb_adr_i == sdbae_pkg::OFS_CTRL) begin
                ctrl_reg <= wb_dat_i[7:1];
                ctrl_reg[sdbae_pkg::CTRL_ROW] <= 1'b0;
            end
            if (wb_adr_i == sdbae_pkg::OFS_COL) begin
                col_reg <= wb_dat_i[COL_W-1:0];
            end
            if (wb_adr_i == sdbae_pkg::OFS_CFG) begin
                cfg_reg <= wb_dat_i[7:0];
            end
        end
    end

    // Write data staging
    always_ff @(posedge clk_i) begin
        if (wr_ok && !busy && dat_hit) begin
            wr_mem[wb_adr_i[4:2]] <= wb_dat_i[15:0];
        end
    end

    // Start and row-open pulses; a start while busy is refused
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            go_reg     <= 1'b0;
            row_reg    <= 1'b0;
            refuse_reg <= 1'b0;
        end else begin
            go_reg  <= 1'b0;
            row_reg <= 1'b0;
            if (wr_ok && wb_adr_i == sdbae_pkg::OFS_CTRL) begin
                row_reg <= wb_dat_i[sdbae_pkg::CTRL_ROW] & ~busy;
                if (wb_dat_i[sdbae_pkg::CTRL_GO]) begin
                    go_reg     <= ~busy;
                    refuse_reg <= busy;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Timers
    // ---------------------------------------------------------------
    // Row-open marks restart the least-active-time guard
    sdbae_timer #(.W(8)) u_tras (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .load_i  (row_reg),
        .value_i (8'(sdbae_pkg::T_RAS_CYC)),
        .done_o  (tras_done)
    );

    // Recovery after a burst before the bank is handed back
    sdbae_timer #(.W(8)) u_recov (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .load_i  (rec_load_reg),
        .value_i (rec_val_reg),
        .done_o  (rec_done)
    );

    // ---------------------------------------------------------------
    // Burst sequencer and pin drive
    // ---------------------------------------------------------------
    // Never issues a second column command inside a burst, so the
    // interrupt cases and auto-precharge hazards cannot arise
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg    <= sdbae_pkg::S_IDLE;
            cmd_reg      <= sdbae_pkg::CMD_NOP;
            addr_reg     <= 12'h000;
            bank_reg     <= 2'h0;
            mask_reg     <= 2'h0;
            dq_reg       <= 16'h0000;
            oe_reg       <= 1'b0;
            cnt_reg      <= 5'h00;
            op_ap_reg    <= 1'b0;
            op_wr_reg    <= 1'b0;
            rec_load_reg <= 1'b0;
            rec_val_reg  <= 8'h00;
        end else begin
            cmd_reg      <= sdbae_pkg::CMD_NOP;
            oe_reg       <= 1'b0;
            mask_reg     <= 2'h0;
            rec_load_reg <= 1'b0;
            cnt_reg      <= cnt_reg + 5'h01;
            unique case (state_reg)
                sdbae_pkg::S_IDLE: begin
                    if (go_reg) begin
                        state_reg <= sdbae_pkg::S_ARM;
                    end
                end
                sdbae_pkg::S_ARM: begin
                    // Auto-precharge waits for the active-time guard
                    if (!ap_eff || tras_done) begin
                        op_ap_reg <= ap_eff;
                        op_wr_reg <= ctrl_reg[sdbae_pkg::CTRL_WR];
                        addr_reg  <= 12'(col_reg);
                        addr_reg[sdbae_pkg::A_AP_BIT] <= ap_eff;
                        bank_reg  <=
                            ctrl_reg[sdbae_pkg::CTRL_BANK_LO +: 2];
                        cnt_reg   <= 5'h01;
                        if (ctrl_reg[sdbae_pkg::CTRL_WR]) begin
                            cmd_reg   <= sdbae_pkg::CMD_WRITE;
                            dq_reg    <= wr_mem[0];
                            oe_reg    <= 1'b1;
                            mask_reg  <=
                                ctrl_reg[sdbae_pkg::CTRL_MASK_LO +: 2];
                            state_reg <= sdbae_pkg::S_WBURST;
                        end else begin
                            cmd_reg   <= sdbae_pkg::CMD_READ;
                            state_reg <= sdbae_pkg::S_RBURST;
                        end
                    end
                end
                sdbae_pkg::S_WBURST: begin
                    if (cnt_reg < 5'(nwords)) begin
                        dq_reg   <= wr_mem[cnt_reg[2:0]];
                        oe_reg   <= 1'b1;
                        mask_reg <= ctrl_reg[sdbae_pkg::CTRL_MASK_LO +: 2];
                    end else begin
                        // Stop only ends full-page bursts
                        if (fp) begin
                            cmd_reg <= sdbae_pkg::CMD_STOP;
                        end
                        rec_load_reg <= 1'b1;
                        rec_val_reg  <= op_ap_reg ?
                            8'(sdbae_pkg::T_DAL_CYC) : 8'h00;
                        state_reg    <= sdbae_pkg::S_RECOV;
                    end
                end
                sdbae_pkg::S_RBURST: begin
                    if (fp && cnt_reg == 5'(nwords)) begin
                        cmd_reg <= sdbae_pkg::CMD_STOP;
                    end
                    // Data floats one latency after the stop
                    if (cnt_reg == 5'(nwords) + 5'(cl)) begin
                        rec_load_reg <= 1'b1;
                        rec_val_reg  <= op_ap_reg ?
                            8'(sdbae_pkg::T_RP_CYC) : 8'h00;
                        state_reg    <= sdbae_pkg::S_RECOV;
                    end
                end
                sdbae_pkg::S_RECOV: begin
                    if (!rec_load_reg && rec_done) begin
                        state_reg <= sdbae_pkg::S_IDLE;
                    end
                end
            endcase
        end
    end

    // Read capture: word k is sampled latency plus k after the command
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_cnt_reg <= 4'h0;
        end else if (state_reg == sdbae_pkg::S_ARM) begin
            rd_cnt_reg <= 4'h0;
        end else if (state_reg == sdbae_pkg::S_RBURST &&
                     cnt_reg > 5'(cl) &&
                     cnt_reg <= 5'(nwords) + 5'(cl)) begin
            rd_mem[ridx[2:0]] <= dq_i;
            rd_cnt_reg        <= rd_cnt_reg + 4'h1;
        end
    end

    // Pin outputs straight from flip-flops; cke_o is tied high
    assign cke_o             = 1'b1;
    assign cs_n_o            = cmd_reg[3];
    assign ras_n_o           = cmd_reg[2];
    assign cas_n_o           = cmd_reg[1];
    assign we_n_o            = cmd_reg[0];
    assign addr_o            = addr_reg;
    assign bank_sel_lo_o     = bank_reg[0];
    assign bank_sel_hi_o     = bank_reg[1];
    assign upper_byte_mask_o = mask_reg[1];
    assign lower_byte_mask_o = mask_reg[0];
    assign dq_o              = dq_reg;
    assign dq_oe_o           = oe_reg;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    read_cmd_a: assert property (
        (state_reg == sdbae_pkg::S_RBURST && cnt_reg == 5'h01) |->
        (!cs_n_o && ras_n_o && !cas_n_o && we_n_o))
        else $error("read command pins wrong");
    write_cmd_a: assert property (
        (state_reg == sdbae_pkg::S_WBURST && cnt_reg == 5'h01) |->
        (!cs_n_o && ras_n_o && !cas_n_o && !we_n_o && dq_oe_o))
        else $error("write command pins wrong");
    write_data_a: assert property (
        $rose(state_reg == sdbae_pkg::S_WBURST) |->
        dq_oe_o [*2] or (nwords == 4'h1))
        else $error("write data not driven each edge");
    stop_fp_a: assert property (
        (cs_n_o == 1'b0 && ras_n_o && cas_n_o && !we_n_o) |-> fp)
        else $error("burst stop outside full page");
    ap_fp_a: assert property (
        (!cas_n_o && addr_o[sdbae_pkg::A_AP_BIT]) |-> !fp)
        else $error("auto-precharge with full page");
    no_interrupt_a: assert property (
        (busy && !(state_reg inside {sdbae_pkg::S_ARM}) &&
         cnt_reg != 5'h01) |-> cas_n_o)
        else $error("column command inside a burst");
    read_float_a: assert property (
        (state_reg == sdbae_pkg::S_RBURST) |-> !dq_oe_o)
        else $error("driving data during a read");
    dal_wait_a: assert property (
        ($rose(state_reg == sdbae_pkg::S_RECOV) && op_ap_reg &&
         op_wr_reg) |-> (state_reg == sdbae_pkg::S_RECOV) [*3])
        else $error("write recovery cut short");
    tras_guard_a: assert property (
        (!cas_n_o && addr_o[sdbae_pkg::A_AP_BIT]) |-> $past(tras_done))
        else $error("auto-precharge before active time");
endmodule

// >>> verif/sdbae_dev_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Memory device model facing the controller
// ---------------------------------------------------------------
module sdbae_dev_model (
    input  wire logic        clk_i,
    input  wire logic [3:0]  cmd_i,
    input  wire logic [11:0] addr_i,
    input  wire logic [1:0]  bank_i,
    input  wire logic [1:0]  mask_i,
    input  wire logic [15:0] dq_i,
    input  wire logic        dq_oe_i,
    input  wire logic [2:0]  bl_i,
    input  wire logic [1:0]  cl_i,
    input  wire logic        ilv_i,
    output logic [15:0]      dq_o,
    output logic             viol_o
);
    logic [15:0] mem [4096];
    logic [9:0]  col;
    logic [1:0]  bk;
    logic        rd, wr, ap, drv;
    int          k, left, dly;

    // Column of word n; turns over inside the aligned block
    function automatic logic [9:0] seq_col(input int n);
        logic [9:0] m;
        m = (bl_i == 3'h7) ? 10'h3FF : 10'((1 << bl_i) - 1);
        if (ilv_i && bl_i != 3'h7)
            return col ^ 10'(n);
        return (col & ~m) | ((col + 10'(n)) & m);
    endfunction

    initial begin
        {viol_o, drv, rd, wr, ap} = 5'h0;
        dq_o = 16'h0;
        left = 0;
    end

    // Read words out, decode, take write words
    always @(posedge clk_i) begin
        drv <= 1'b0;
        dq_o <= ~dq_o; // Released line never holds a stale word
        if (rd && dly > 1)
            dly--;
        else if (rd && left > 0) begin
            dq_o <= mem[{bk, seq_col(k)}];
            drv <= 1'b1;
            k++;
            left--;
        end
        if (drv && dq_oe_i)
            viol_o <= 1'b1;
        if (left == 0)
            {rd, wr, ap} = 3'h0;
        case (cmd_i)
            4'h5, 4'h4: begin
                if (ap && (rd || wr))
                    viol_o <= 1'b1;
                ap = addr_i[10];
                if (ap && bl_i == 3'h7)
                    viol_o <= 1'b1;
                rd = cmd_i[0];
                wr = !cmd_i[0];
                col = addr_i[9:0];
                bk = bank_i;
                k = 0;
                dly = cl_i - 1;
                left = (bl_i == 3'h7) ? 1024 : 1 << bl_i;
            end
            4'h6: begin
                if (bl_i != 3'h7)
                    viol_o <= 1'b1;
                left = rd ? cl_i - 2 : 0;
            end
            default: ;
        endcase
        if (wr && left > 0) begin
            if (!dq_oe_i)
                viol_o <= 1'b1;
            if (!mask_i[0])
                mem[{bk, seq_col(k)}][7:0] = dq_i[7:0];
            if (!mask_i[1])
                mem[{bk, seq_col(k)}][15:8] = dq_i[15:8];
            k++;
            left--;
        end
    end
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Bench for the burst access controller
// ---------------------------------------------------------------
module tb;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    wire  [3:0]  cmd;
    wire  [1:0]  bs, dm;
    logic [11:0] addr_o;
    logic [15:0] dq_o, dq_i, dev_dq;
    logic        dq_oe_o, ilv, viol, cke;
    logic [2:0]  bl;
    logic [1:0]  cl, b;
    logic [9:0]  c;
    logic [15:0] shd [4096];
    int          n, errors, samples_checked;

    // Controller wins the data line while it drives
    assign dq_i = dq_oe_o ? dq_o : dev_dq;

    sdbae_ctrl i_sdbae_ctrl (
        .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cke_o(cke),
        .cs_n_o(cmd[3]), .ras_n_o(cmd[2]), .cas_n_o(cmd[1]),
        .we_n_o(cmd[0]), .addr_o, .bank_sel_lo_o(bs[0]),
        .bank_sel_hi_o(bs[1]), .upper_byte_mask_o(dm[1]),
        .lower_byte_mask_o(dm[0]), .dq_o, .dq_oe_o, .dq_i
    );

    sdbae_dev_model i_sdbae_dev_model (
        .clk_i, .cmd_i(cmd), .addr_i(addr_o), .bank_i(bs), .mask_i(dm),
        .dq_i, .dq_oe_i(dq_oe_o), .bl_i(bl), .cl_i(cl), .ilv_i(ilv),
        .dq_o(dev_dq), .viol_o(viol)
    );

    // Expected column of word k of the current burst
    function automatic logic [9:0] ecol(input int k);
        logic [9:0] m;
        m = (bl == 3'h7) ? 10'h3FF : 10'((1 << bl) - 1);
        if (ilv && bl != 3'h7)
            return c ^ 10'(k);
        return (c & ~m) | ((c + 10'(k)) & m);
    endfunction

    task automatic chk(input string s, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask

    // One classic cycle, held until ack is seen at an edge
    task automatic wb(input logic [7:0] a, input logic w,
                      input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask

    // Poll status until the sequencer is idle
    task automatic idle();
        int t;
        t = 0;
        do begin
            wb(8'h0C, 1'b0, 32'h0, 4'hF);
            t++;
        end while (q[0] !== 1'b0 && t < 60);
        if (t >= 60)
            errors++;
    endtask

    task automatic print_verdict();
        if (errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // Hang guard, well beyond the expected run
    initial begin
        #(40 * 20000);
        errors++;
        print_verdict();
    end

    // Main sequence
    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, ilv} = 5'h10;
        {wb_adr_i, wb_sel_i, wb_dat_i, bl, cl} = {44'h0, 3'h3, 2'h2};
        {errors, samples_checked} = 64'h0;
        for (int a = 0; a < 4096; a++) begin
            shd[a] = {4'hA, 12'(a)};
            i_sdbae_dev_model.mem[a] = shd[a];
        end
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(8'h08, 1'b0, 32'h0, 4'hF);
        chk("cfg", 32'h0000_00F3, q);
        wb(8'hFC, 1'b0, 32'h0, 4'hF);
        chk("unmapped", 32'h0, q);
        // Every length, both latencies, both orders; read then write
        for (int i = 0; i < 20; i++) begin
            @(posedge clk_i);
            bl <= 3'(i / 4 == 4 ? 7 : i / 4);
            cl <= 2'(2 + i % 2);
            ilv <= i[1];
            @(posedge clk_i);
            n = (bl == 3'h7) ? 5 : 1 << bl;
            c = (n == 5) ? 10'h3FE : 10'h3F0 + 10'(i * 3);
            b = 2'(i % 4);
            wb(8'h08, 1'b1, {24'h0, 3'h4, cl, bl}, 4'hF);
            wb(8'h04, 1'b1, {22'h0, c}, 4'hF);
            wb(8'h00, 1'b1, 32'h0000_0020, 4'hF);
            wb(8'h00, 1'b1, {27'h0, b, cl[0], 2'h1}, 4'hF);
            idle();
            for (int k = 0; k < n; k++) begin
                wb(8'(32 + 4 * k), 1'b0, 32'h0, 4'hF);
                chk("rdata", {16'h0, shd[{b, ecol(k)}]},
                    q & 32'hFFFF);
            end
            wb(8'h0C, 1'b0, 32'h0, 4'hF);
            chk("count", 32'(n), {28'h0, q[5:2]});
            for (int k = 0; k < n; k++) begin
                shd[{b, ecol(k)}] = 16'(16'hC000 + i * 16 + k);
                wb(8'(32 + 4 * k), 1'b1, {16'h0, shd[{b, ecol(k)}]}, 4'hF);
            end
            wb(8'h00, 1'b1, {27'h0, b, cl[0], 2'h3}, 4'hF);
            idle();
            for (int k = 0; k <= n; k++)
                chk("wdata", {16'h0, shd[{b, ecol(k)}]},
                    {16'h0, i_sdbae_dev_model.mem[{b, ecol(k)}]});
        end
        // Lower byte lane masked on every word
        @(posedge clk_i);
        {bl, cl, ilv} <= 6'h1C;
        wb(8'h08, 1'b1, 32'h0000_0013, 4'hF);
        wb(8'h04, 1'b1, 32'h0000_0100, 4'hF);
        for (int k = 0; k < 8; k++)
            wb(8'(32 + 4 * k), 1'b1, 32'(16'h9E00 + k), 4'hF);
        wb(8'h00, 1'b1, 32'h0000_0043, 4'hF);
        idle();
        for (int k = 0; k < 8; k++)
            chk("mask", {16'h0, 8'h9E, shd[12'h100 + k][7:0]},
                {16'h0, i_sdbae_dev_model.mem[12'h100 + k]});
        // Narrow write ignored, then go while busy refused
        wb(8'h04, 1'b1, 32'h0000_00AA, 4'hF);
        wb(8'h04, 1'b1, 32'h0000_0155, 4'hC);
        wb(8'h04, 1'b0, 32'h0, 4'hF);
        chk("col", 32'h0000_00AA, q & 32'h3FF);
        wb(8'h00, 1'b1, 32'h0000_0001, 4'hF);
        wb(8'h00, 1'b1, 32'h0000_0001, 4'hF);
        wb(8'h0C, 1'b0, 32'h0, 4'hF);
        chk("refused", 32'h3, q & 32'h3);
        idle();
        wb(8'h00, 1'b1, 32'h0000_0001, 4'hF);
        idle();
        chk("refuse clear", 32'h0, q & 32'h3);
        chk("far side", 32'h0, {31'h0, viol});
        chk("cke", 32'h1, {31'h0, cke});
        print_verdict();
    end
endmodule
